// *** two_wire_serial_io_interface.sv ***
`timescale 1ns/10ps
module two_wire_serial_io_interface #(
  parameter int DIV_UNIT = sio_pkg::DIV_UNIT_CYCLES,
  parameter int HOLD_CYCLES = sio_pkg::START_HOLD_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [1:0] REG_SEL,
  input wire logic WR_STB,
  input wire logic [7:0] WR_DATA,
  output logic [7:0] RD_DATA,
  input wire logic SI_INT_ENABLE,
  output logic SERIAL_INT_REQ,
  input wire logic PORT2_LINE3,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE_N
);
  if (HOLD_CYCLES < 4 || HOLD_CYCLES >= (1 << sio_pkg::WAIT_W))
  begin : g_bad_hold
    $error("two_wire_serial_io_interface: HOLD_CYCLES out of range");
  end

  localparam logic [sio_pkg::WAIT_W-1:0] HOLD_LAST =
    sio_pkg::WAIT_W'(HOLD_CYCLES - 1);

  // pin synchronisers and edge history
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  // software visible state
  logic [7:0] shift_reg;
  logic [7:0] own_address_reg;
  logic [6:0] clock_ctrl_reg;
  logic serial_enable_reg;
  logic [2:0] bit_counter_reg;
  logic master_select_reg, transmit_select_reg;
  logic bus_occupied_flag_reg, pending_n_reg;
  logic arbitration_lost_flag_reg, slave_selected_flag_reg;
  logic general_call_flag_reg, last_rx_bit_reg;
  logic [7:0] rd_data_reg;

  // transfer engine
  sio_pkg::state_e state_reg;
  logic got_all_reg, ack_phase_reg, first_byte_reg;
  logic sda_low_reg, scl_low_reg, stop_phase_reg;
  logic [sio_pkg::WAIT_W-1:0] wait_reg;

  logic wr_shift, wr_stat, wr_clk;
  logic start_req, start_refused, stop_req, pin_clear;
  logic in_xfer, sending, tx_after, ack_mode, match_en;
  logic addr_match, gc_match, addr_phase, ignored;
  logic bit_rise, arb_lost, enter_ack, last_fall;
  logic byte_end, addr_hit, stop_done, restart, bus_stop;

  sclk_if link ();

  sclk_gen #(.UNIT(DIV_UNIT)) u_gen (
    .clk(CLOCK),
    .rst(RST),
    .link(link)
  );

  assign link.run = master_select_reg && state_reg == sio_pkg::ST_XFER;
  assign link.rate = clock_ctrl_reg[sio_pkg::CK_RATE_MSB:0];
  assign link.asym = clock_ctrl_reg[sio_pkg::CK_ASYM];
  assign link.line_high = scl_s2_reg;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
    end else begin
      sda_s1_reg <= SDA_IN;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
      scl_s1_reg <= SCL_IN;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
    end
  end

  assign scl_rise = scl_s2_reg && !scl_d_reg;
  assign scl_fall = !scl_s2_reg && scl_d_reg;
  assign start_cond = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
  assign stop_cond = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;

  // register port decode
  assign wr_shift = WR_STB && REG_SEL == sio_pkg::SEL_SHIFT;
  assign wr_stat = WR_STB && REG_SEL == sio_pkg::SEL_STATUS;
  assign wr_clk = WR_STB && REG_SEL == sio_pkg::SEL_CLOCK;
  assign start_req = wr_stat && WR_DATA[sio_pkg::ST_MST]
    && WR_DATA[sio_pkg::ST_BB] && serial_enable_reg
    && !bus_occupied_flag_reg && state_reg == sio_pkg::ST_IDLE;
  // a start asked for while another master holds the bus is refused
  assign start_refused = wr_stat && WR_DATA[sio_pkg::ST_MST]
    && WR_DATA[sio_pkg::ST_BB] && serial_enable_reg
    && bus_occupied_flag_reg && !master_select_reg;
  assign stop_req = wr_stat && WR_DATA[sio_pkg::ST_MST]
    && !WR_DATA[sio_pkg::ST_BB] && master_select_reg
    && state_reg == sio_pkg::ST_HOLD;
  assign pin_clear = wr_stat && WR_DATA[sio_pkg::ST_PIN];

  // transfer events
  assign in_xfer = state_reg == sio_pkg::ST_XFER;
  assign sending = transmit_select_reg;
  assign tx_after = wr_stat ? WR_DATA[sio_pkg::ST_TRX] : transmit_select_reg;
  assign ack_mode = clock_ctrl_reg[sio_pkg::CK_ACK];
  assign match_en = own_address_reg[sio_pkg::OA_MATCH_EN];
  assign gc_match = shift_reg[7:1] == sio_pkg::GENERAL_CALL_ADDR;
  assign addr_match = gc_match
    || shift_reg[7:1] == own_address_reg[7:sio_pkg::OA_ADDR_LSB];
  assign addr_phase = first_byte_reg && match_en && !master_select_reg;
  // with recognition off every byte is data, so nothing is ignored
  assign ignored = addr_phase && !addr_match;
  assign bit_rise = in_xfer && scl_rise && !ack_phase_reg;
  // we released the line for a one but somebody pulls it low
  assign arb_lost = bit_rise && sending && master_select_reg
    && !sda_low_reg && !sda_s2_reg;
  assign enter_ack = in_xfer && scl_fall && got_all_reg && !ack_phase_reg
    && ack_mode;
  assign last_fall = in_xfer && scl_fall && got_all_reg
    && (ack_phase_reg || !ack_mode);
  assign byte_end = last_fall && !ignored;
  assign addr_hit = last_fall && addr_phase && addr_match;
  assign stop_done = state_reg == sio_pkg::ST_STOP && stop_phase_reg
    && scl_s2_reg && wait_reg == HOLD_LAST;
  assign restart = start_cond && state_reg != sio_pkg::ST_START
    && state_reg != sio_pkg::ST_STOP && !start_req;
  assign bus_stop = stop_cond && state_reg != sio_pkg::ST_START
    && state_reg != sio_pkg::ST_STOP;

  // configuration written by software
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      serial_enable_reg <= 1'b0;
      own_address_reg <= sio_pkg::OWN_ADDR_RESET;
      clock_ctrl_reg <= sio_pkg::CLOCK_CTRL_RESET;
    end else begin
      if (wr_stat)
        serial_enable_reg <= WR_DATA[sio_pkg::ST_ESO];
      if (wr_shift && !serial_enable_reg)
        own_address_reg <= WR_DATA;
      if (wr_clk)
        clock_ctrl_reg <= WR_DATA[6:0];
    end
  end

  // operating mode: hardware outcomes override software writes
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      master_select_reg <= 1'b0;
      transmit_select_reg <= 1'b0;
    end else if (arb_lost) begin
      master_select_reg <= 1'b0;
      transmit_select_reg <= 1'b0;
    end else if (stop_done) begin
      master_select_reg <= 1'b0;
      transmit_select_reg <= 1'b0;
    end else if (addr_hit) begin
      transmit_select_reg <= shift_reg[0];
    end else if (bus_stop && !master_select_reg) begin
      transmit_select_reg <= 1'b0;
    end else if (wr_stat) begin
      master_select_reg <= WR_DATA[sio_pkg::ST_MST] && !start_refused;
      transmit_select_reg <= WR_DATA[sio_pkg::ST_TRX] && !start_refused;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST)
      bus_occupied_flag_reg <= 1'b0;
    else if (!serial_enable_reg)
      bus_occupied_flag_reg <= 1'b0;
    else if (start_cond)
      bus_occupied_flag_reg <= 1'b1;
    else if (stop_cond)
      bus_occupied_flag_reg <= 1'b0;
  end

  // pending is active low; a completed byte wins over a clear
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST)
      pending_n_reg <= 1'b1;
    else if (byte_end)
      pending_n_reg <= 1'b0;
    else if (pin_clear)
      pending_n_reg <= 1'b1;
  end

  // hardware status flags; setting wins over clearing
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      arbitration_lost_flag_reg <= 1'b0;
      slave_selected_flag_reg <= 1'b0;
      general_call_flag_reg <= 1'b0;
    end else begin
      if (arb_lost || start_refused)
        arbitration_lost_flag_reg <= 1'b1;
      else if (start_req)
        arbitration_lost_flag_reg <= 1'b0;
      if (addr_hit)
        slave_selected_flag_reg <= 1'b1;
      else if (start_cond || stop_cond)
        slave_selected_flag_reg <= 1'b0;
      if (addr_hit && gc_match)
        general_call_flag_reg <= 1'b1;
      else if (start_cond || stop_cond)
        general_call_flag_reg <= 1'b0;
    end
  end

  // byte engine: bits shift on rising clock, data changes on falling
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_reg <= sio_pkg::ST_IDLE;
      shift_reg <= sio_pkg::SHIFT_RESET;
      bit_counter_reg <= sio_pkg::BIT_COUNT_RESET;
      last_rx_bit_reg <= 1'b0;
      got_all_reg <= 1'b0;
      ack_phase_reg <= 1'b0;
      first_byte_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      stop_phase_reg <= 1'b0;
      wait_reg <= '0;
    end else begin
      if (wr_shift && serial_enable_reg)
        shift_reg <= WR_DATA;
      if (wr_stat)
        bit_counter_reg <= WR_DATA[sio_pkg::ST_BC_MSB:0];
      if (!serial_enable_reg) begin
        state_reg <= sio_pkg::ST_IDLE;
        sda_low_reg <= 1'b0;
        scl_low_reg <= 1'b0;
        got_all_reg <= 1'b0;
        ack_phase_reg <= 1'b0;
        first_byte_reg <= 1'b0;
      end else if (restart) begin
        state_reg <= sio_pkg::ST_XFER;
        first_byte_reg <= 1'b1;
        bit_counter_reg <= sio_pkg::BIT_COUNT_RESET;
        got_all_reg <= 1'b0;
        ack_phase_reg <= 1'b0;
        sda_low_reg <= 1'b0;
        scl_low_reg <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= sio_pkg::ST_IDLE;
        sda_low_reg <= 1'b0;
        scl_low_reg <= 1'b0;
        got_all_reg <= 1'b0;
        ack_phase_reg <= 1'b0;
        first_byte_reg <= 1'b0;
      end else begin
        case (state_reg)
          sio_pkg::ST_IDLE: begin
            if (start_req) begin
              state_reg <= sio_pkg::ST_START;
              sda_low_reg <= 1'b1;
              wait_reg <= '0;
            end
          end
          sio_pkg::ST_START: begin
            if (wait_reg == HOLD_LAST) begin
              state_reg <= sio_pkg::ST_XFER;
              first_byte_reg <= 1'b1;
              bit_counter_reg <= sio_pkg::BIT_COUNT_RESET;
              got_all_reg <= 1'b0;
              ack_phase_reg <= 1'b0;
            end else begin
              wait_reg <= wait_reg + 1'b1;
            end
          end
          sio_pkg::ST_XFER: begin
            if (bit_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s2_reg};
              last_rx_bit_reg <= sda_s2_reg;
              bit_counter_reg <= bit_counter_reg + 1'b1;
              if (bit_counter_reg == sio_pkg::BIT_COUNT_LAST)
                got_all_reg <= 1'b1;
              if (arb_lost)
                sda_low_reg <= 1'b0;
            end
            if (scl_rise && ack_phase_reg)
              last_rx_bit_reg <= sda_s2_reg;
            if (enter_ack) begin
              if (ignored) begin
                state_reg <= sio_pkg::ST_SKIP;
                sda_low_reg <= 1'b0;
              end else begin
                ack_phase_reg <= 1'b1;
                sda_low_reg <= !sending;
              end
            end else if (last_fall) begin
              state_reg <= ignored ? sio_pkg::ST_SKIP : sio_pkg::ST_HOLD;
              scl_low_reg <= !ignored;
              sda_low_reg <= 1'b0;
              got_all_reg <= 1'b0;
              ack_phase_reg <= 1'b0;
              first_byte_reg <= 1'b0;
            end else if (scl_fall && !got_all_reg) begin
              sda_low_reg <= sending && !shift_reg[7];
            end
          end
          sio_pkg::ST_HOLD: begin
            if (stop_req) begin
              state_reg <= sio_pkg::ST_STOP;
              stop_phase_reg <= 1'b0;
              wait_reg <= '0;
              sda_low_reg <= 1'b1;
            end else if (pin_clear) begin
              state_reg <= sio_pkg::ST_XFER;
              scl_low_reg <= 1'b0;
              sda_low_reg <= tx_after && !shift_reg[7];
            end
          end
          sio_pkg::ST_STOP: begin
            if (!stop_phase_reg) begin
              if (wait_reg == HOLD_LAST) begin
                stop_phase_reg <= 1'b1;
                scl_low_reg <= 1'b0;
                wait_reg <= '0;
              end else begin
                wait_reg <= wait_reg + 1'b1;
              end
            end else if (scl_s2_reg) begin
              if (wait_reg == HOLD_LAST) begin
                state_reg <= sio_pkg::ST_IDLE;
                sda_low_reg <= 1'b0;
              end else begin
                wait_reg <= wait_reg + 1'b1;
              end
            end
          end
          sio_pkg::ST_SKIP: begin
            sda_low_reg <= 1'b0;
          end
          default: begin
            state_reg <= sio_pkg::ST_IDLE;
            sda_low_reg <= 1'b0;
            scl_low_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // read port: enable and bit counter are never returned
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rd_data_reg <= 8'h00;
    end else begin
      case (REG_SEL)
        sio_pkg::SEL_SHIFT: rd_data_reg <= shift_reg;
        sio_pkg::SEL_STATUS: rd_data_reg <= {master_select_reg,
          transmit_select_reg, bus_occupied_flag_reg, pending_n_reg,
          arbitration_lost_flag_reg, slave_selected_flag_reg,
          general_call_flag_reg, last_rx_bit_reg};
        default: rd_data_reg <= 8'h00;
      endcase
    end
  end

  assign RD_DATA = rd_data_reg;
  assign SERIAL_INT_REQ = SI_INT_ENABLE && !pending_n_reg;

  // both lines open drain; data pin is a port line while disabled
  assign SDA_OUT = 1'b0;
  assign SDA_OE_N = serial_enable_reg ? !sda_low_reg : PORT2_LINE3;
  assign SCL_OUT = 1'b0;
  assign SCL_OE_N = !(serial_enable_reg
    && (link.drive_low || scl_low_reg));
endmodule

// *** sio_pkg.sv ***
// Function
// - bytes shift out MSB first, same register receives
// - pending raised only on complete byte or address
// - master and transmit bits pick the mode
// - pending flag low means pending, gates request
// - serial enable switches the whole interface
// - three-bit counter holds bits done this byte
// - enable and bit counter are write-only
// - master transmitter losing arbitration sets lost flag
// - own or general call address sets selected flag
// - bus busy bit follows start and stop
// - data pin serial when enabled; both open drain
// - status word shares upper nibble, lower differs
// - seven-bit address; answer own or general call
// - arbitration keeps one transmitter on the bus
// - without address recognition bytes pass directly
// - general call sets general call flag
// - last received bit or acknowledge is kept
package sio_pkg;
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int START_HOLD_NS = 4000;
  localparam int START_HOLD_CYCLES =
    (START_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DIV_UNIT_NS = 5000;
  localparam int DIV_UNIT_CYCLES = DIV_UNIT_NS / CLOCK_PERIOD_NS;
  localparam int WAIT_W = 16;
  localparam int GEN_W = 18;

  localparam logic [1:0] SEL_SHIFT = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h1;
  localparam logic [1:0] SEL_CLOCK = 2'h2;

  localparam int ST_MST = 7;
  localparam int ST_TRX = 6;
  localparam int ST_BB = 5;
  localparam int ST_PIN = 4;
  localparam int ST_ESO = 3;
  localparam int ST_BC_MSB = 2;
  localparam int CK_RATE_MSB = 4;
  localparam int CK_ASYM = 5;
  localparam int CK_ACK = 6;
  localparam int OA_ADDR_LSB = 1;
  localparam int OA_MATCH_EN = 0;

  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
  localparam logic [6:0] CLOCK_CTRL_RESET = 7'h00;
  localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
  localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_XFER = 3'b010,
    ST_HOLD = 3'b011,
    ST_STOP = 3'b100,
    ST_SKIP = 3'b101
  } state_e;
endpackage

// *** sclk_if.sv ***
`timescale 1ns/10ps
interface sclk_if;
  logic run;
  logic [4:0] rate;
  logic asym;
  logic line_high;
  logic drive_low;
  modport gen(input run, input rate, input asym, input line_high,
              output drive_low);
  modport ctl(output run, output rate, output asym, output line_high,
              input drive_low);
endinterface

// *** sclk_gen.sv ***
`timescale 1ns/10ps
module sclk_gen #(
  parameter int UNIT = sio_pkg::DIV_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  sclk_if.gen link
);
  if (UNIT < 1 || UNIT * 96 >= (1 << sio_pkg::GEN_W)) begin : g_bad_unit
    $error("sclk_gen: UNIT out of range");
  end

  logic [sio_pkg::GEN_W-1:0] cnt_reg;
  logic high_phase_reg;
  logic [sio_pkg::GEN_W-1:0] len;

  // one phase length; asymmetric clock is high three quarters of the period
  function automatic logic [sio_pkg::GEN_W-1:0] phase_len(
    input logic [4:0] rate, input logic asym, input logic high);
    logic [sio_pkg::GEN_W-1:0] q;
    q = sio_pkg::GEN_W'(({13'h0000, rate} + 18'h00001)
        * sio_pkg::GEN_W'(UNIT));
    if (!asym)
      phase_len = sio_pkg::GEN_W'(q << 1);
    else if (high)
      phase_len = sio_pkg::GEN_W'(q * 3);
    else
      phase_len = q;
  endfunction

  assign len = phase_len(link.rate, link.asym, high_phase_reg);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      high_phase_reg <= 1'b0;
    end else if (!link.run) begin
      cnt_reg <= '0;
      high_phase_reg <= 1'b0;
    end else if (high_phase_reg && !link.line_high) begin
      // line held low elsewhere: stretch or a faster master
      cnt_reg <= cnt_reg;
    end else if (cnt_reg >= len - 1'b1) begin
      cnt_reg <= '0;
      high_phase_reg <= ~high_phase_reg;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // low phase starts at once when run rises so the line never glitches
  assign link.drive_low = link.run && !high_phase_reg;
endmodule

// *** sio_sva.sv ***
`timescale 1ns/10ps
module sio_sva #(
  parameter int DIV_UNIT = 2,
  parameter int HOLD_CYCLES = 8
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [1:0] REG_SEL,
  input wire logic WR_STB,
  input wire logic [7:0] WR_DATA,
  input wire logic [7:0] RD_DATA,
  input wire logic SI_INT_ENABLE,
  input wire logic SERIAL_INT_REQ,
  input wire logic PORT2_LINE3,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  input wire logic SCL_IN,
  input wire logic SCL_OUT,
  input wire logic SCL_OE_N
);
  logic en_reg;
  logic busy_reg;
  logic sda_d_reg;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      en_reg <= 1'b0;
    end else if (WR_STB && REG_SEL == sio_pkg::SEL_STATUS) begin
      en_reg <= WR_DATA[sio_pkg::ST_ESO];
    end
  end
  // raw start and stop conditions seen on the pins
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sda_d_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else begin
      sda_d_reg <= SDA_IN;
      if (SCL_IN && sda_d_reg != SDA_IN) begin
        busy_reg <= !SDA_IN;
      end
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence start_request;
    WR_STB && REG_SEL == sio_pkg::SEL_STATUS && WR_DATA[7:5] == 3'h7 &&
      WR_DATA[sio_pkg::ST_ESO] && en_reg && !busy_reg;
  endsequence
  sequence start_hold;
    (!SDA_OE_N && SCL_OE_N) [*4];
  endsequence
  a_open_drain_low: assert property (!SDA_OUT && !SCL_OUT)
    else $error("pin output level not low");
  a_req_needs_enable: assert property (SERIAL_INT_REQ |-> SI_INT_ENABLE)
    else $error("interrupt request without enable");
  a_idle_data_follows: assert property (!en_reg && !$past(en_reg) &&
    $stable(PORT2_LINE3) |-> SDA_OE_N == PORT2_LINE3)
    else $error("data pin not following port latch");
  a_idle_clock_free: assert property (!en_reg && !$past(en_reg) |-> SCL_OE_N)
    else $error("clock pin driven while disabled");
  a_reset_quiet: assert property ($fell(RST) |->
    RD_DATA == 8'h00 && !SERIAL_INT_REQ && SCL_OE_N)
    else $error("outputs not quiet after reset");
  a_clock_word_hidden: assert property (REG_SEL[1] |=> RD_DATA == 8'h00)
    else $error("write-only or unmapped place read nonzero");
  a_start_holds_data: assert property (start_request |=> start_hold)
    else $error("start condition not held");
  a_pending_holds_clock: assert property ($rose(SERIAL_INT_REQ) &&
    $past(SI_INT_ENABLE) |-> !SCL_IN ##[0:2] !SCL_OE_N)
    else $error("pending raised outside clock low or clock not held");
endmodule
bind two_wire_serial_io_interface sio_sva #(.DIV_UNIT(DIV_UNIT),
  .HOLD_CYCLES(HOLD_CYCLES)) chk (.CLOCK(CLOCK), .RST(RST),
  .REG_SEL(REG_SEL), .WR_STB(WR_STB), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA),
  .SI_INT_ENABLE(SI_INT_ENABLE), .SERIAL_INT_REQ(SERIAL_INT_REQ),
  .PORT2_LINE3(PORT2_LINE3), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE_N(SDA_OE_N), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT),
  .SCL_OE_N(SCL_OE_N));

// *** bus_peer.sv ***
`timescale 1ns/10ps
module bus_peer (
  input wire logic sda,
  input wire logic scl,
  output logic sda_n,
  output logic scl_n
);
  initial begin
    sda_n = 1'b1;
    scl_n = 1'b1;
  end
  // slave side: stretches the clock before its acknowledge
  task automatic take_byte(input int stretch, output logic [7:0] b);
    repeat (8) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
    @(negedge scl);
    scl_n = 1'b0;
    #20 sda_n = 1'b0;
    #(stretch) scl_n = 1'b1;
    @(negedge scl);
    #20 sda_n = 1'b1;
  endtask
  // slave transmitter side: bits change after each falling clock
  task automatic give_byte(input logic [7:0] b);
    sda_n = b[7];
    for (int i = 6; i >= 0; i--) begin
      @(negedge scl);
      #20 sda_n = b[i];
    end
    @(negedge scl);
    #20 sda_n = 1'b1;
  endtask
  // a second master pulls data low against our first one bit
  task automatic clash;
    @(negedge scl);
    #20 sda_n = 1'b0;
    @(posedge scl);
    #400 sda_n = 1'b1;
  endtask
  task automatic clk_bit(input logic b, output logic s);
    sda_n = b;
    #20 scl_n = 1'b1;
    wait (scl);
    #40 s = sda;
    scl_n = 1'b0;
    #20;
  endtask
  task automatic start_c;
    wait (sda && scl);
    #40 sda_n = 1'b0;
    #40 scl_n = 1'b0;
    #20;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, ack);
  endtask
  task automatic stop_c;
    sda_n = 1'b0;
    #20 scl_n = 1'b1;
    wait (scl);
    #40 sda_n = 1'b1;
    #40;
  endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [1:0] reg_sel = 2'h0;
  logic wr_stb = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic si_en = 1'b0;
  logic p23 = 1'b1;
  logic [7:0] rd_data;
  logic [7:0] v;
  logic int_req, sda_out, sda_oe_n, scl_out, scl_oe_n, pk_sda_n, pk_scl_n;
  wire sda = sda_oe_n & pk_sda_n;
  wire scl = scl_oe_n & pk_scl_n;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;

  always #4 clock = ~clock;

  two_wire_serial_io_interface #(.DIV_UNIT(2), .HOLD_CYCLES(8)) dut (
    .CLOCK(clock), .RST(rst), .REG_SEL(reg_sel), .WR_STB(wr_stb),
    .WR_DATA(wr_data), .RD_DATA(rd_data), .SI_INT_ENABLE(si_en),
    .SERIAL_INT_REQ(int_req), .PORT2_LINE3(p23), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .SCL_IN(scl),
    .SCL_OUT(scl_out), .SCL_OE_N(scl_oe_n));
  bus_peer peer (.sda(sda), .scl(scl), .sda_n(pk_sda_n), .scl_n(pk_scl_n));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    @(negedge clock);
    reg_sel = sel;
    wr_data = d;
    wr_stb = 1'b1;
    @(negedge clock);
    wr_stb = 1'b0;
  endtask
  task automatic rd(input logic [1:0] sel, output logic [7:0] d);
    @(negedge clock);
    reg_sel = sel;
    @(negedge clock);
    d = rd_data;
  endtask
  task automatic wait_status(input int bit_n, input logic lvl);
    for (int i = 0; i < 2000; i++) begin
      rd(sio_pkg::SEL_STATUS, v);
      if (v[bit_n] === lvl) break;
    end
    check({7'h0, v[bit_n]}, {7'h0, lvl});
  endtask

  task automatic test_reset;
    rd(sio_pkg::SEL_STATUS, v);
    check(v, 8'h10);
    rd(sio_pkg::SEL_CLOCK, v);
    check(v, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h3, v);
    check(v, 8'h00);
    rd(sio_pkg::SEL_STATUS, v);
    check(v, 8'h10);
    p23 = 1'b0;
    repeat (3) @(negedge clock);
    check({7'h0, sda_oe_n}, 8'h00);
    p23 = 1'b1;
    repeat (3) @(negedge clock);
    check({5'h0, sda_oe_n, scl_oe_n, int_req}, 8'h06);
    $display("test_reset done");
  endtask

  task automatic test_master_tx;
    logic [7:0] got;
    wr(sio_pkg::SEL_CLOCK, 8'h40);
    wr(sio_pkg::SEL_STATUS, 8'h08);
    rd(sio_pkg::SEL_STATUS, v);
    check(v, 8'h10);
    wr(sio_pkg::SEL_SHIFT, 8'hA5);
    fork
      wr(sio_pkg::SEL_STATUS, 8'hE8);
      peer.take_byte(200, got);
    join
    wait_status(sio_pkg::ST_PIN, 1'b0);
    check(got, 8'hA5);
    check(v, 8'hE0);
    si_en = 1'b1;
    @(negedge clock);
    check({7'h0, int_req}, 8'h01);
    si_en = 1'b0;
    @(negedge clock);
    check({7'h0, int_req}, 8'h00);
    fork
      wr(sio_pkg::SEL_STATUS, 8'hB8);
      peer.give_byte(8'h3C);
    join
    wait_status(sio_pkg::ST_PIN, 1'b0);
    check(v, 8'hA0);
    rd(sio_pkg::SEL_SHIFT, v);
    check(v, 8'h3C);
    wr(sio_pkg::SEL_STATUS, 8'hD8);
    wait_status(sio_pkg::ST_BB, 1'b0);
    check({v[7], v[4], 6'h0}, 8'h40);
    wr(sio_pkg::SEL_SHIFT, 8'hA5);
    fork
      wr(sio_pkg::SEL_STATUS, 8'hE8);
      peer.clash();
    join
    repeat (4) @(negedge clock);
    rd(sio_pkg::SEL_STATUS, v);
    check(v, 8'h18);
    $display("test_master_tx done");
  endtask

  task automatic test_slave_rx;
    logic [7:0] addr [3] = '{8'hAA, 8'h00, 8'h54};
    logic [1:0] kind [3] = '{2'h1, 2'h3, 2'h0};
    logic ack;
    wr(sio_pkg::SEL_STATUS, 8'h00);
    wr(sio_pkg::SEL_SHIFT, 8'hAB);
    wr(sio_pkg::SEL_STATUS, 8'h08);
    si_en = 1'b1;
    for (int i = 0; i < 3; i++) begin
      peer.start_c();
      peer.put_byte(addr[i], ack);
      check({7'h0, ack}, {7'h0, !kind[i][0]});
      repeat (4) @(negedge clock);
      rd(sio_pkg::SEL_STATUS, v);
      check({v[5:4], v[2:1], 4'h0},
        {1'b1, !kind[i][0], kind[i][0], kind[i][1], 4'h0});
      if (kind[i][0]) begin
        wr(sio_pkg::SEL_STATUS, 8'h18);
      end
      if (i == 2) begin
        wr(sio_pkg::SEL_STATUS, 8'hE8);
        rd(sio_pkg::SEL_STATUS, v);
        check({v[7], v[3], 6'h0}, 8'h40);
      end
      peer.stop_c();
    end
    si_en = 1'b0;
    $display("test_slave_rx done");
  endtask

  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    test_reset();
    test_master_tx();
    test_slave_rx();
    end_of_test();
  end
endmodule
